// [design/alu_defines.svh]
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

// instruction fields, bit 15 of the word is the class bit
`define CLASS_BIT    15
`define SRC_IDX_LSB        13
`define DST_IDX_LSB        11
`define OP_LSB             8
`define SHIFT_SEL_LSB      6
`define CARRY_BASE_LSB     4
`define STORE_SUPPRESS_BIT 3
`define SKIP_TEST_LSB      0

// address width and register byte offsets
`define AXI_ADDR_W   8
`define OFS_ACC0     8'h00
`define OFS_ACC1     8'h04
`define OFS_ACC2     8'h08
`define OFS_ACC3     8'h0c
`define OFS_CARRY    8'h10
`define OFS_INSTR    8'h14
`define OFS_STATUS   8'h18
`define OFS_RESULT   8'h1c

// status bit positions
`define ST_SKIP_BIT  0
`define ST_FOREIGN_BIT 1
`define ST_BUSY_BIT  2

// reset values and responses
`define ACC_RST      16'h0000
`define CARRY_RST    1'h0
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// [design/alu_pkg.sv]
`include "alu_defines.svh"
package alu_pkg;
  typedef enum logic [2:0] {
    ONES_INVERT_OP, TWOS_NEGATE_OP, PASS_THROUGH_OP, INCREMENT_OP,
    ADD_INVERSE_OP, SUBTRACT_OP, ADD_BOTH_OP, AND_BOTH_OP
  } op_e;
  typedef enum logic [1:0] {
    SHIFT_NONE, ROTATE_LEFT, ROTATE_RIGHT, BYTE_SWAP
  } shift_e;
  typedef enum logic [1:0] {
    BASE_FLAG, BASE_ZERO, BASE_ONE, BASE_FLAG_INV
  } carry_e;
  typedef enum logic [2:0] {
    NEVER_BYPASS, ALWAYS_BYPASS, BYPASS_ON_CARRY_CLEAR,
    BYPASS_ON_CARRY_SET, BYPASS_ON_RESULT_ZERO, BYPASS_ON_RESULT_NONZERO,
    BYPASS_ON_EITHER_ZERO, BYPASS_ON_BOTH_NONZERO
  } skip_e;
  typedef struct packed {
    logic [3:0][15:0]         acc;
    logic                     carry;
    logic [15:0]              instr;
    logic                     pend;
    logic                     skip;
    logic                     foreign;
    logic                     skip_p;
    logic [16:0]              last;
    logic                     aw_h;
    logic [`AXI_ADDR_W-1:0]   aw_a;
    logic                     w_h;
    logic [31:0]              w_d;
    logic [3:0]               w_s;
    logic                     bvalid;
    logic [1:0]               bresp;
    logic                     rvalid;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
  } regs_s;
endpackage

// [design/alu_if.sv]
interface alu_if;
  logic [15:0] instr;
  logic [15:0] src;
  logic [15:0] dst;
  logic        flag;
  logic        base;
  logic [15:0] alu_res;
  logic        alu_resulting_carry;
  logic [15:0] res;
  logic        shifted_carry;
  logic        skip;
  logic        load;
  modport core (output instr, src, dst, flag,
                input  base, alu_res, alu_resulting_carry, res,
                       shifted_carry, skip, load);
  modport dp   (input  instr, src, dst, flag,
                output base, alu_res, alu_resulting_carry, res,
                       shifted_carry, skip, load);
endinterface

// [design/alu_datapath.sv]
`include "alu_defines.svh"
module alu_datapath
  import alu_pkg::*;
(
  alu_if.dp bus
);
  logic [15:0] a;
  logic [15:0] b;
  logic        cin;
  logic        arith;
  logic [16:0] sum;
  logic        zero;

  always_comb begin
    case (carry_e'(bus.instr[`CARRY_BASE_LSB +: 2]))
      BASE_FLAG: bus.base = bus.flag;
      BASE_ZERO: bus.base = 1'h0;
      BASE_ONE:  bus.base = 1'h1;
      default:   bus.base = ~bus.flag;
    endcase
    a = bus.src;
    b = 16'h0;
    cin = 1'h0;
    arith = 1'h1;
    bus.alu_res = 16'h0;
    // subtraction is inverse plus carry-in, so carry-out marks no borrow
    case (op_e'(bus.instr[`OP_LSB +: 3]))
      ONES_INVERT_OP: begin
        arith = 1'h0;
        bus.alu_res = ~bus.src;
      end
      TWOS_NEGATE_OP: begin
        a = ~bus.src;
        cin = 1'h1;
      end
      PASS_THROUGH_OP: begin
        arith = 1'h0;
        bus.alu_res = bus.src;
      end
      INCREMENT_OP: cin = 1'h1;
      ADD_INVERSE_OP: begin
        a = bus.dst;
        b = ~bus.src;
      end
      SUBTRACT_OP: begin
        a = bus.dst;
        b = ~bus.src;
        cin = 1'h1;
      end
      ADD_BOTH_OP: begin
        a = bus.dst;
        b = bus.src;
      end
      default: begin
        arith = 1'h0;
        bus.alu_res = bus.src & bus.dst;
      end
    endcase
    sum = {1'h0, a} + {1'h0, b} + {16'h0, cin};
    if (arith) begin
      bus.alu_res = sum[15:0];
    end
    bus.alu_resulting_carry = bus.base ^ (arith & sum[16]);
    case (shift_e'(bus.instr[`SHIFT_SEL_LSB +: 2]))
      SHIFT_NONE: begin
        bus.res = bus.alu_res;
        bus.shifted_carry = bus.alu_resulting_carry;
      end
      ROTATE_LEFT: begin
        bus.res = {bus.alu_res[14:0], bus.alu_resulting_carry};
        bus.shifted_carry = bus.alu_res[15];
      end
      ROTATE_RIGHT: begin
        bus.res = {bus.alu_resulting_carry, bus.alu_res[15:1]};
        bus.shifted_carry = bus.alu_res[0];
      end
      default: begin
        bus.res = {bus.alu_res[7:0], bus.alu_res[15:8]};
        bus.shifted_carry = bus.alu_resulting_carry;
      end
    endcase
    zero = (bus.res == 16'h0);
    case (skip_e'(bus.instr[`SKIP_TEST_LSB +: 3]))
      NEVER_BYPASS:             bus.skip = 1'h0;
      ALWAYS_BYPASS:            bus.skip = 1'h1;
      BYPASS_ON_CARRY_CLEAR:    bus.skip = ~bus.shifted_carry;
      BYPASS_ON_CARRY_SET:      bus.skip = bus.shifted_carry;
      BYPASS_ON_RESULT_ZERO:    bus.skip = zero;
      BYPASS_ON_RESULT_NONZERO: bus.skip = ~zero;
      BYPASS_ON_EITHER_ZERO:    bus.skip = ~bus.shifted_carry | zero;
      default:                  bus.skip = bus.shifted_carry & ~zero;
    endcase
    bus.load = ~bus.instr[`STORE_SUPPRESS_BIT];
  end
endmodule

// [design/alu_shift_carry_skip_unit.sv]
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`include "alu_defines.svh"
module alu_shift_carry_skip_unit
  import alu_pkg::*;
(
  input  wire logic                   REF_CLK_I,
  input  wire logic                   RESETN_I,
  input  wire logic [`AXI_ADDR_W-1:0] AWADDR_I,
  input  wire logic                   AWVALID_I,
  output logic                        AWREADY_O,
  input  wire logic [31:0]            WDATA_I,
  input  wire logic [3:0]             WSTRB_I,
  input  wire logic                   WVALID_I,
  output logic                        WREADY_O,
  output logic [1:0]                  BRESP_O,
  output logic                        BVALID_O,
  input  wire logic                   BREADY_I,
  input  wire logic [`AXI_ADDR_W-1:0] ARADDR_I,
  input  wire logic                   ARVALID_I,
  output logic                        ARREADY_O,
  output logic [31:0]                 RDATA_O,
  output logic [1:0]                  RRESP_O,
  output logic                        RVALID_O,
  input  wire logic                   RREADY_I,
  output logic                        SKIP_REQ_O,
  output logic                        EXEC_BUSY_O
);
  regs_s       st_r;
  regs_s       st_nxt;
  logic [1:0]  src_idx;
  logic [1:0]  dst_idx;
  logic        exec;
  logic        wr_go;
  logic        wr_err;
  logic [31:0] rd_data;
  logic        rd_err;
  op_e         op_w;
  shift_e      shift_w;
  skip_e       skip_w;
  logic        res_carry_w;
  logic        new_carry_w;

  alu_if dp();

  alu_datapath u_dp (
    .bus (dp)
  );

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand routing

  assign src_idx = st_r.instr[`SRC_IDX_LSB +: 2];
  assign dst_idx = st_r.instr[`DST_IDX_LSB +: 2];
  assign exec    = st_r.pend & st_r.instr[`CLASS_BIT];
  assign op_w    = op_e'(st_r.instr[`OP_LSB +: 3]);
  assign shift_w = shift_e'(st_r.instr[`SHIFT_SEL_LSB +: 2]);
  assign skip_w  = skip_e'(st_r.instr[`SKIP_TEST_LSB +: 3]);

  assign res_carry_w = dp.alu_resulting_carry;
  assign new_carry_w = dp.shifted_carry;

  assign dp.instr = st_r.instr;
  assign dp.src   = st_r.acc[src_idx];
  assign dp.dst   = st_r.acc[dst_idx];
  assign dp.flag  = st_r.carry;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  assign wr_go = st_r.aw_h & st_r.w_h & ~st_r.bvalid & ~st_r.pend;

  always_comb begin
    wr_err = 1'h0;
    if (st_r.aw_a == `OFS_ACC0 || st_r.aw_a == `OFS_ACC1 ||
        st_r.aw_a == `OFS_ACC2 || st_r.aw_a == `OFS_ACC3) begin
      wr_err = 1'h0;
    end else if (st_r.aw_a == `OFS_CARRY || st_r.aw_a == `OFS_INSTR) begin
      wr_err = 1'h0;
    end else begin
      wr_err = 1'h1;
    end
  end

  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'h0;
    if (ARADDR_I == `OFS_ACC0) begin
      rd_data = {16'h0, st_r.acc[0]};
    end else if (ARADDR_I == `OFS_ACC1) begin
      rd_data = {16'h0, st_r.acc[1]};
    end else if (ARADDR_I == `OFS_ACC2) begin
      rd_data = {16'h0, st_r.acc[2]};
    end else if (ARADDR_I == `OFS_ACC3) begin
      rd_data = {16'h0, st_r.acc[3]};
    end else if (ARADDR_I == `OFS_CARRY) begin
      rd_data = {31'h0, st_r.carry};
    end else if (ARADDR_I == `OFS_INSTR) begin
      rd_data = {16'h0, st_r.instr};
    end else if (ARADDR_I == `OFS_STATUS) begin
      rd_data[`ST_SKIP_BIT]    = st_r.skip;
      rd_data[`ST_FOREIGN_BIT] = st_r.foreign;
      rd_data[`ST_BUSY_BIT]    = st_r.pend;
    end else if (ARADDR_I == `OFS_RESULT) begin
      rd_data = {15'h0, st_r.last};
    end else begin
      rd_err = 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;
    st_nxt.skip_p = 1'h0;
    if (AWVALID_I && !st_r.aw_h) begin
      st_nxt.aw_h = 1'h1;
      st_nxt.aw_a = AWADDR_I;
    end
    if (WVALID_I && !st_r.w_h) begin
      st_nxt.w_h = 1'h1;
      st_nxt.w_d = WDATA_I;
      st_nxt.w_s = WSTRB_I;
    end
    if (st_r.bvalid && BREADY_I) begin
      st_nxt.bvalid = 1'h0;
    end
    // writes wait while an instruction executes, so no clash on acc
    if (wr_go) begin
      st_nxt.aw_h   = 1'h0;
      st_nxt.w_h    = 1'h0;
      st_nxt.bvalid = 1'h1;
      st_nxt.bresp  = wr_err ? `RESP_SLVERR : `RESP_OKAY;
      if (st_r.aw_a == `OFS_ACC0) begin
        st_nxt.acc[0] = merge16(st_r.acc[0], st_r.w_d, st_r.w_s);
      end else if (st_r.aw_a == `OFS_ACC1) begin
        st_nxt.acc[1] = merge16(st_r.acc[1], st_r.w_d, st_r.w_s);
      end else if (st_r.aw_a == `OFS_ACC2) begin
        st_nxt.acc[2] = merge16(st_r.acc[2], st_r.w_d, st_r.w_s);
      end else if (st_r.aw_a == `OFS_ACC3) begin
        st_nxt.acc[3] = merge16(st_r.acc[3], st_r.w_d, st_r.w_s);
      end else if (st_r.aw_a == `OFS_CARRY) begin
        st_nxt.carry = st_r.w_s[0] ? st_r.w_d[0] : st_r.carry;
      end else if (st_r.aw_a == `OFS_INSTR) begin
        st_nxt.instr = merge16(st_r.instr, st_r.w_d, st_r.w_s);
        st_nxt.pend  = 1'h1;
      end
    end
    if (st_r.rvalid && RREADY_I) begin
      st_nxt.rvalid = 1'h0;
    end
    if (ARVALID_I && !st_r.rvalid) begin
      st_nxt.rvalid = 1'h1;
      st_nxt.rdata  = rd_data;
      st_nxt.rresp  = rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (st_r.pend) begin
      st_nxt.pend = 1'h0;
      if (exec) begin
        if (dp.load) begin
          st_nxt.acc[dst_idx] = dp.res;
          st_nxt.carry        = dp.shifted_carry;
        end
        st_nxt.skip    = dp.skip;
        st_nxt.skip_p  = dp.skip;
        st_nxt.last    = {dp.shifted_carry, dp.res};
        st_nxt.foreign = 1'h0;
      end else begin
        st_nxt.skip    = 1'h0;
        st_nxt.foreign = 1'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign AWREADY_O   = ~st_r.aw_h;
  assign WREADY_O    = ~st_r.w_h;
  assign BVALID_O    = st_r.bvalid;
  assign BRESP_O     = st_r.bresp;
  assign ARREADY_O   = ~st_r.rvalid;
  assign RVALID_O    = st_r.rvalid;
  assign RDATA_O     = st_r.rdata;
  assign RRESP_O     = st_r.rresp;
  assign SKIP_REQ_O  = st_r.skip_p;
  assign EXEC_BUSY_O = st_r.pend;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);

  invert_op_a: assert property (
    exec && op_w == ONES_INVERT_OP |->
      dp.alu_res == ~dp.src && res_carry_w == dp.base)
    else $error("invert op wrong");
  negate_op_a: assert property (
    exec && op_w == TWOS_NEGATE_OP |->
      dp.alu_res == 16'(16'h0 - dp.src) &&
      res_carry_w == (dp.base ^ (dp.src == 16'h0)))
    else $error("negate op wrong");
  pass_op_a: assert property (
    exec && op_w == PASS_THROUGH_OP |->
      dp.alu_res == dp.src && res_carry_w == dp.base)
    else $error("pass op wrong");
  incr_op_a: assert property (
    exec && op_w == INCREMENT_OP |->
      dp.alu_res == 16'(dp.src + 16'h1) &&
      res_carry_w == (dp.base ^ (dp.alu_res == 16'h0)))
    else $error("increment op wrong");
  add_inverse_a: assert property (
    exec && op_w == ADD_INVERSE_OP |->
      dp.alu_res == 16'(dp.dst + ~dp.src) &&
      res_carry_w == (dp.base ^ (dp.src < dp.dst)))
    else $error("add inverse wrong");
  subtract_op_a: assert property (
    exec && op_w == SUBTRACT_OP |->
      dp.alu_res == 16'(dp.dst - dp.src) &&
      res_carry_w == (dp.base ^ (dp.src <= dp.dst)))
    else $error("subtract wrong");
  add_both_a: assert property (
    exec && op_w == ADD_BOTH_OP |->
      dp.alu_res == 16'(dp.dst + dp.src) &&
      res_carry_w == (dp.base ^ (({1'h0, dp.dst} + {1'h0, dp.src}) >=
                                 17'h10000)))
    else $error("add wrong");
  and_op_a: assert property (
    exec && op_w == AND_BOTH_OP |->
      dp.alu_res == (dp.src & dp.dst) && res_carry_w == dp.base)
    else $error("and op wrong");
  no_shift_a: assert property (
    exec && shift_w == SHIFT_NONE |-> dp.res == dp.alu_res &&
      new_carry_w == res_carry_w)
    else $error("no shift altered data");
  rot_left_a: assert property (
    exec && shift_w == ROTATE_LEFT |->
      {new_carry_w, dp.res} == {dp.alu_res, res_carry_w})
    else $error("left rotate wrong");
  rot_right_a: assert property (
    exec && shift_w == ROTATE_RIGHT |->
      {dp.res, new_carry_w} == {res_carry_w, dp.alu_res})
    else $error("right rotate wrong");
  byte_swap_a: assert property (
    exec && shift_w == BYTE_SWAP |->
      dp.res == {dp.alu_res[7:0], dp.alu_res[15:8]} &&
      new_carry_w == res_carry_w)
    else $error("swap wrong");
  carry_base_a: assert property (
    exec |-> dp.base == (st_r.instr[`CARRY_BASE_LSB + 1] ?
      (st_r.instr[`CARRY_BASE_LSB] ? ~st_r.carry : 1'h1) :
      (st_r.instr[`CARRY_BASE_LSB] ? 1'h0 : st_r.carry)))
    else $error("carry base wrong");
  logic_carry_a: assert property (
    exec && (op_w == AND_BOTH_OP || op_w == PASS_THROUGH_OP ||
             op_w == ONES_INVERT_OP) |->
      res_carry_w == dp.base)
    else $error("logic op touched carry");
  store_a: assert property (
    exec && dp.load |=> st_r.acc[$past(dst_idx)] == $past(dp.res) &&
      st_r.carry == $past(new_carry_w))
    else $error("result not stored");
  no_store_a: assert property (
    exec && !dp.load |=> $stable(st_r.acc) && $stable(st_r.carry))
    else $error("no-load still stored");
  skip_carry_a: assert property (
    exec && (skip_w == BYPASS_ON_CARRY_CLEAR ||
             skip_w == BYPASS_ON_CARRY_SET)
      |-> dp.skip == (new_carry_w == st_r.instr[`SKIP_TEST_LSB]))
    else $error("carry skip wrong");
  skip_fixed_a: assert property (
    exec && (skip_w == NEVER_BYPASS || skip_w == ALWAYS_BYPASS) |->
      dp.skip == st_r.instr[`SKIP_TEST_LSB])
    else $error("fixed skip wrong");
  skip_mixed_a: assert property (
    exec && skip_w == BYPASS_ON_BOTH_NONZERO |->
      dp.skip == (new_carry_w && dp.res != 16'h0))
    else $error("combined skip wrong");
  skip_result_a: assert property (
    exec && (skip_w == BYPASS_ON_RESULT_ZERO ||
             skip_w == BYPASS_ON_RESULT_NONZERO) |->
      dp.skip == ((dp.res == 16'h0) ^ st_r.instr[`SKIP_TEST_LSB]))
    else $error("result skip wrong");
  skip_either_a: assert property (
    exec && skip_w == BYPASS_ON_EITHER_ZERO |->
      dp.skip == (!new_carry_w || dp.res == 16'h0))
    else $error("either-zero skip wrong");
  // a request must only follow an executed word, never a bus write
  skip_quiet_a: assert property (
    !st_r.pend |=> !SKIP_REQ_O)
    else $error("skip request without a word");
  skip_pulse_a: assert property (
    exec |=> SKIP_REQ_O == $past(dp.skip) ##1 !SKIP_REQ_O)
    else $error("skip request not one pulse");
  foreign_word_a: assert property (
    st_r.pend && !exec |=> !SKIP_REQ_O && $stable(st_r.acc))
    else $error("foreign word executed");
  operand_sel_a: assert property (
    exec |-> dp.src == st_r.acc[st_r.instr[14:13]] &&
      dp.dst == st_r.acc[st_r.instr[12:11]])
    else $error("operand select wrong");
  noload_skip_a: assert property (
    exec && !dp.load && skip_w == BYPASS_ON_RESULT_ZERO |->
      dp.skip == (dp.res == 16'h0))
    else $error("skip lost under no-load");
  resp_hold_a: assert property (
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped");
  read_hold_a: assert property (
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) &&
      $stable(RRESP_O))
    else $error("read data dropped");
  busy_pulse_a: assert property (
    EXEC_BUSY_O |=> !EXEC_BUSY_O)
    else $error("busy longer than one cycle");

  skip_taken_c: cover property (exec && dp.skip ##1 SKIP_REQ_O);
  noload_skip_c: cover property (exec && !dp.load && dp.skip);
  rotate_store_c: cover property (exec && shift_w == ROTATE_LEFT && dp.load);
  bad_read_c: cover property (RVALID_O && RRESP_O == `RESP_SLVERR);
endmodule

// [dv/seq_model.sv]
module seq_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        skip_i,
  output logic [15:0]      pc_o,
  output logic [15:0]      err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic                    prev_r;
  // sequencer side: each bypass request steps the program counter once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o   <= 16'h0000;
      err_o  <= 16'h0000;
      prev_r <= 1'b0;
    end else begin
      prev_r <= skip_i;
      if (skip_i) pc_o <= pc_o + 16'h0001;
      // a two-cycle request would bypass two words
      if (skip_i && prev_r) err_o <= err_o + 16'h0001;
    end
  end
endmodule

// [dv/alu_shift_carry_skip_unit_tb.sv]
`include "alu_defines.svh"
module alu_shift_carry_skip_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, skip_req, busy;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pc, perr, v, ins;
  logic [15:0] m_acc [4];
  logic        m_c;
  logic [15:0] lfsr = 16'h0040;
  logic [2:0]  b_q [$];
  logic [33:0] r_q [$];
  int          bad_count = 0;
  int          n_checks = 0;
  int          n_skip = 0;
  ////////////////////////////////////////////////////////////////////////
  always #20 clk = ~clk;
  alu_shift_carry_skip_unit i_dut (
    .REF_CLK_I(clk), .RESETN_I(rst_n),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
    .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready),
    .SKIP_REQ_O(skip_req), .EXEC_BUSY_O(busy)
  );
  seq_model i_seq (
    .clk_i(clk), .rst_n_i(rst_n), .skip_i(skip_req),
    .pc_o(pc), .err_o(perr)
  );
  ////////////////////////////////////////////////////////////////////////
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
    n_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task fail();
    bad_count++;
    results();
  endtask
  // results are compared as they appear on the bus, oldest note first
  always @(posedge clk) begin
    // busy is high at the answer edge only for a word just committed
    if (bvalid === 1'b1 && bready) begin
      chk("bresp busy", 34'({busy, bresp}), 34'(b_q.pop_front()));
    end
    if (rvalid === 1'b1 && rready) begin
      chk("rdata", {rresp, rdata}, r_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] e);
    int k;
    @(posedge clk);
    b_q.push_back({a == `OFS_INSTR, e});
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (k == 200) fail();
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    @(posedge clk);
    r_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 200; k++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (k == 200) fail();
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reference: carry base, operation, carry rule, shifter, skip test
  task automatic run(input logic [15:0] w);
    logic [15:0] s, d, r;
    logic        b, c, co, hit;
    logic [7:0]  t;
    s = m_acc[w[14:13]];
    d = m_acc[w[12:11]];
    case (w[5:4])
      2'h0: b = m_c;
      2'h1: b = 1'b0;
      2'h2: b = 1'b1;
      default: b = ~m_c;
    endcase
    co = 1'b0;
    r = s;
    case (w[10:8])
      3'h0: r = ~s;
      3'h1: {co, r} = {s == 16'h0000, 16'h0000 - s};
      3'h3: {co, r} = {s == 16'hffff, s + 16'h0001};
      3'h4: {co, r} = {s < d, d + ~s};
      3'h5: {co, r} = {s <= d, d - s};
      3'h6: {co, r} = {1'b0, s} + {1'b0, d};
      3'h7: r = s & d;
      default: r = s;
    endcase
    c = b ^ co;
    case (w[7:6])
      2'h1: {c, r} = {r, c};
      2'h2: {c, r} = {r[0], c, r[15:1]};
      2'h3: r = {r[7:0], r[15:8]};
      default: r = r;
    endcase
    t = {c & |r, ~c | ~|r, |r, ~|r, c, ~c, 1'b1, 1'b0};
    hit = t[w[2:0]];
    wr(`OFS_INSTR, {16'h0, w}, 4'h3, `RESP_OKAY);
    if (!w[3]) begin
      m_acc[w[12:11]] = r;
      m_c = c;
    end
    n_skip += hit;
    rd(`OFS_RESULT, {17'h0, c, r});
    rd(`OFS_STATUS, {33'h0, hit});
    rd({4'h0, w[12:11], 2'h0}, {18'h0, m_acc[w[12:11]]});
    rd(`OFS_CARRY, {33'h0, m_c});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    m_c = 1'b0;
    for (int j = 0; j < 4; j++) m_acc[j] = 16'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int j = 0; j < 8; j++) rd(8'(j * 4), 34'h0);
    rd(8'h20, {`RESP_SLVERR, 32'h0});
    wr(`OFS_STATUS, 32'h7, 4'hf, `RESP_SLVERR);
    wr(`OFS_RESULT, 32'h1, 4'hf, `RESP_SLVERR);
    wr(`OFS_ACC0, 32'h1234, 4'hf, `RESP_OKAY);
    wr(`OFS_ACC0, 32'habcd, 4'h1, `RESP_OKAY);
    m_acc[0] = 16'h12cd;
    rd(`OFS_ACC0, {18'h0, m_acc[0]});
    $display("test registers done");
    // edge operands: all zero, all ones, all equal, then random
    for (int i = 0; i < 96; i++) begin
      for (int j = 0; j < 4; j++) begin
        v = rnd();
        if (i % 6 == 0) v = 16'h0000;
        if (i % 6 == 1) v = 16'hffff;
        if (i % 6 == 2) v = 16'h5a5a;
        m_acc[j] = v;
        wr(8'(j * 4), {16'h0, v}, 4'h3, `RESP_OKAY);
      end
      v = rnd();
      m_c = v[0];
      wr(`OFS_CARRY, {31'h0, m_c}, 4'h1, `RESP_OKAY);
      ins = rnd();
      ins[15] = 1'b1;
      ins[10:8] = i[2:0];
      ins[7:6] = i[4:3];
      ins[5:4] = i[6:5] ^ v[2:1];
      ins[2:0] = 3'((i / 3) % 8);
      run(ins);
    end
    $display("test execute done");
    run(16'h8000);
    wr(`OFS_INSTR, 32'h7fff, 4'h3, `RESP_OKAY);
    rd(`OFS_STATUS, 34'h2);
    rd(`OFS_ACC3, {18'h0, m_acc[3]});
    rd(`OFS_CARRY, {33'h0, m_c});
    $display("test foreign word done");
    repeat (4) @(posedge clk);
    chk("skip count", {18'h0, pc}, 34'(n_skip));
    chk("skip width", {18'h0, perr}, 34'h0);
    $display("test skip requests done");
    results();
  end
endmodule
